// ===== s100_slave_board_access.sv
`timescale 1ns/1ps
`include "s100_slave_map.svh"
module s100_slave_board_access #(
  parameter int SRC_DIV = `SRC_DIV
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [15:0] host_addr,
  input wire logic [7:0] host_ext_addr,
  input wire logic [7:0] host_data_out,
  input wire s100_slave_pkg::host_status_t host_status,
  input wire logic [3:0] board_id_sw,
  input wire logic [7:0] page_sw,
  input wire logic m1_wait_en,
  input wire logic holdoff_long,
  input wire logic mem_256k,
  input wire logic local_bus_grant_n,
  input wire logic opcode_fetch_cycle,
  input wire logic refresh_strobe_n,
  input wire logic cpu_addr7,
  input wire logic local_io_req,
  input wire logic [7:0] local_io_addr,
  input wire logic [5:2] uart_op,
  input wire logic ext_cycle_done,
  output logic host_wait,
  output logic inbound_buffer_en_n,
  output logic outbound_buffer_en_n,
  output logic local_bus_request,
  output logic local_wait_n,
  output logic cpu_clock,
  output logic synced_grant_n,
  output logic mem_addr_bit7,
  output s100_slave_pkg::ext_strobes_t ext_strobes,
  output logic uart_chip_select_n,
  output logic [3:0] uart_reg_addr,
  output logic board_select_strobe_n,
  output logic control_latch_strobe_n,
  output logic host_selected_flag,
  output logic local_cpu_reset_n,
  output logic dma_board_flag_n,
  output logic [1:0] mem_bank,
  output logic memory_window_hit_n,
  output logic board_valid_n
);
  // ==========================================
  // Clock, synchronised grant, refresh address
  logic cpu_tick;

  local_clock_refresh #(
    .SRC_DIV(SRC_DIV)
  ) u_clk (
    .core_clk(core_clk),
    .resetn(resetn),
    .local_bus_grant_n(local_bus_grant_n),
    .refresh_strobe_n(refresh_strobe_n),
    .cpu_addr7(cpu_addr7),
    .cpu_clock(cpu_clock),
    .cpu_tick(cpu_tick),
    .synced_grant_n(synced_grant_n),
    .mem_addr_bit7(mem_addr_bit7)
  );

  function automatic logic port_is(input logic [15:0] a, input logic [15:0] p);
    port_is = (a == p);
  endfunction

  // ==========================================
  // Decode
  logic sel_q, sel_d;
  logic [3:0] latch_q, latch_d;
  logic bsel_n_q, bsel_n_d;
  logic clat_n_q, clat_n_d;
  logic wr_prev_q, wr_prev_d;
  logic [15:0] wr_addr_q, wr_addr_d;
  logic [7:0] wr_data_q, wr_data_d;
  logic dma_n_q, dma_n_d;
  logic io_write, io_read, mem_rd, mem_wr;
  logic uart_port, win_hit, valid, mem_acc, io_acc, any_acc;

  always_comb begin
    io_write = host_status.out & ~host_status.wr_n;
    io_read = host_status.inp & host_status.dbin;
    mem_rd = host_status.memr & host_status.dbin;
    mem_wr = ~host_status.memr & ~host_status.wo_n & ~host_status.out & ~host_status.inp
             & ~host_status.wr_n;
    // DMA and host may each aim at a different board
    valid = host_status.hlda ? latch_q[`LATCH_DMA_BIT] : sel_q;
    win_hit = (host_ext_addr == page_sw) & valid;
    uart_port = (host_addr & `UART_PORT_MASK) == `UART_PORT_BASE;
    mem_acc = win_hit & (mem_rd | mem_wr);
    io_acc = sel_q & uart_port & (io_read | io_write);
    any_acc = mem_acc | io_acc;
    sel_d = sel_q;
    latch_d = latch_q;
    wr_prev_d = io_write;
    wr_addr_d = io_write ? host_addr : wr_addr_q;
    wr_data_d = io_write ? host_data_out : wr_data_q;
    // Select and latch ports bypass the internal bus entirely
    bsel_n_d = ~(io_write & port_is(host_addr, `BOARD_SELECT_PORT));
    clat_n_d = ~(io_write & sel_q & port_is(host_addr, `CONTROL_LATCH_PORT));
    // Captured when the write strobe ends
    if (wr_prev_q && !io_write) begin
      if (port_is(wr_addr_q, `BOARD_SELECT_PORT)) begin
        sel_d = (wr_data_q[3:0] == board_id_sw);
      end
      if (port_is(wr_addr_q, `CONTROL_LATCH_PORT) && sel_q) begin
        latch_d = wr_data_q[3:0];
      end
    end
    dma_n_d = ~latch_d[`LATCH_DMA_BIT];
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sel_q <= 1'b0;
      latch_q <= `LATCH_RESET;
      bsel_n_q <= 1'b1;
      clat_n_q <= 1'b1;
      wr_prev_q <= 1'b0;
      wr_addr_q <= 16'h0000;
      wr_data_q <= 8'h00;
      dma_n_q <= 1'b1;
    end else begin
      sel_q <= sel_d;
      latch_q <= latch_d;
      bsel_n_q <= bsel_n_d;
      clat_n_q <= clat_n_d;
      wr_prev_q <= wr_prev_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      dma_n_q <= dma_n_d;
    end
  end

  // ==========================================
  // External access sequencing
  s100_slave_pkg::access_state_t st_q, st_d;
  logic [3:0] hold_q, hold_d;
  logic [3:0] burst_q, burst_d;
  logic req_q, req_d;
  logic wait_q, wait_d;
  s100_slave_pkg::ext_strobes_t stb_q, stb_d;
  logic is_mem_q, is_mem_d;
  logic is_rd_q, is_rd_d;

  always_comb begin
    st_d = st_q;
    hold_d = hold_q;
    burst_d = burst_q;
    is_mem_d = is_mem_q;
    is_rd_d = is_rd_q;
    wait_d = wait_q;
    if (cpu_tick && hold_q != 4'h0) begin
      hold_d = hold_q - 4'h1;
    end
    case (st_q)
      s100_slave_pkg::ST_IDLE: begin
        if (any_acc) begin
          st_d = s100_slave_pkg::ST_REQ;
          wait_d = 1'b1;
          is_mem_d = mem_acc;
          is_rd_d = mem_rd | io_read;
        end
      end
      s100_slave_pkg::ST_REQ: begin
        if (!synced_grant_n) begin
          st_d = s100_slave_pkg::ST_RUN;
        end
      end
      s100_slave_pkg::ST_RUN: begin
        if (ext_cycle_done) begin
          st_d = s100_slave_pkg::ST_DONE;
          wait_d = 1'b0;
          burst_d = burst_q + 4'h1;
          hold_d = holdoff_long ? `HOLDOFF_LONG : `HOLDOFF_SHORT;
        end
      end
      s100_slave_pkg::ST_DONE: begin
        if (!any_acc) begin
          // Bursting host would starve refresh otherwise
          st_d = (burst_q >= `BURST_MAX) ? s100_slave_pkg::ST_YIELD
                                           : s100_slave_pkg::ST_IDLE;
        end
      end
      s100_slave_pkg::ST_YIELD: begin
        hold_d = 4'h0;
        // A requester arriving now must wait out the local cycle
        if (any_acc) begin
          wait_d = 1'b1;
        end
        if (local_bus_grant_n && cpu_tick) begin
          burst_d = 4'h0;
          st_d = s100_slave_pkg::ST_IDLE;
        end
      end
      default: begin
        st_d = s100_slave_pkg::ST_IDLE;
      end
    endcase
    if (st_q == s100_slave_pkg::ST_IDLE && hold_q == 4'h0 && !any_acc) begin
      burst_d = 4'h0;
    end
    req_d = (st_d == s100_slave_pkg::ST_REQ) || (st_d == s100_slave_pkg::ST_RUN)
            || (st_d == s100_slave_pkg::ST_DONE)
            || (st_d == s100_slave_pkg::ST_IDLE && hold_d != 4'h0);
    stb_d = '{mreq_n: 1'b1, iorq_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
    if (st_d == s100_slave_pkg::ST_RUN) begin
      stb_d.mreq_n = ~is_mem_d;
      stb_d.iorq_n = is_mem_d;
      stb_d.rd_n = ~is_rd_d;
      stb_d.wr_n = is_rd_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= s100_slave_pkg::ST_IDLE;
      hold_q <= 4'h0;
      burst_q <= 4'h0;
      req_q <= 1'b0;
      wait_q <= 1'b0;
      stb_q <= '{mreq_n: 1'b1, iorq_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
      is_mem_q <= 1'b0;
      is_rd_q <= 1'b0;
    end else begin
      st_q <= st_d;
      hold_q <= hold_d;
      burst_q <= burst_d;
      req_q <= req_d;
      wait_q <= wait_d;
      stb_q <= stb_d;
      is_mem_q <= is_mem_d;
      is_rd_q <= is_rd_d;
    end
  end

  // ==========================================
  // Local side: opcode wait, UART select, banks, buffers
  logic m1_prev_q, m1_prev_d;
  logic lwait_q, lwait_d;
  logic ucs_n_q, ucs_n_d;
  logic [3:0] ureg_q, ureg_d;
  logic [1:0] bank_q, bank_d;
  logic din_n_q, din_n_d;
  logic dout_n_q, dout_n_d;
  logic hit_n_q, hit_n_d;
  logic vbd_n_q, vbd_n_d;

  always_comb begin
    m1_prev_d = opcode_fetch_cycle;
    lwait_d = lwait_q;
    if (m1_wait_en && opcode_fetch_cycle && !m1_prev_q) begin
      lwait_d = 1'b0;
    end else if (cpu_tick) begin
      lwait_d = 1'b1;
    end
    if (!local_bus_grant_n) begin
      ucs_n_d = ~(st_d == s100_slave_pkg::ST_RUN && !is_mem_d);
      ureg_d = host_addr[3:0];
    end else begin
      ucs_n_d = ~local_io_req;
      ureg_d = local_io_addr[3:0];
    end
    if (!mem_256k) begin
      bank_d = 2'h0;
    end else if (local_bus_grant_n) begin
      bank_d = uart_op[5:4];
    end else if (host_status.hlda) begin
      bank_d = uart_op[3:2];
    end else begin
      bank_d = latch_q[`LATCH_BANK_HI:`LATCH_BANK_LO];
    end
    din_n_d = ~(any_acc & host_status.dbin);
    dout_n_d = ~(any_acc & ~local_bus_grant_n);
    hit_n_d = ~win_hit;
    vbd_n_d = ~valid;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      m1_prev_q <= 1'b0;
      lwait_q <= 1'b1;
      ucs_n_q <= 1'b1;
      ureg_q <= 4'h0;
      bank_q <= 2'h0;
      din_n_q <= 1'b1;
      dout_n_q <= 1'b1;
      hit_n_q <= 1'b1;
      vbd_n_q <= 1'b1;
    end else begin
      m1_prev_q <= m1_prev_d;
      lwait_q <= lwait_d;
      ucs_n_q <= ucs_n_d;
      ureg_q <= ureg_d;
      bank_q <= bank_d;
      din_n_q <= din_n_d;
      dout_n_q <= dout_n_d;
      hit_n_q <= hit_n_d;
      vbd_n_q <= vbd_n_d;
    end
  end

  assign host_wait = wait_q;
  assign inbound_buffer_en_n = din_n_q;
  assign outbound_buffer_en_n = dout_n_q;
  assign local_bus_request = req_q;
  assign local_wait_n = lwait_q;
  assign ext_strobes = stb_q;
  assign uart_chip_select_n = ucs_n_q;
  assign uart_reg_addr = ureg_q;
  assign board_select_strobe_n = bsel_n_q;
  assign control_latch_strobe_n = clat_n_q;
  assign host_selected_flag = sel_q;
  assign local_cpu_reset_n = latch_q[`LATCH_RUN_BIT];
  assign dma_board_flag_n = dma_n_q;
  assign mem_bank = bank_q;
  assign memory_window_hit_n = hit_n_q;
  assign board_valid_n = vbd_n_q;
endmodule

// ===== s100_slave_map.svh
`ifndef S100_SLAVE_MAP_SVH
`define S100_SLAVE_MAP_SVH
// ==========================================
// Host I/O ports
`define BOARD_SELECT_PORT 16'hFC40
`define CONTROL_LATCH_PORT 16'hFC41
`define UART_PORT_BASE 16'hFC30
`define UART_PORT_MASK 16'hFFF0
// ==========================================
// Control latch fields
`define LATCH_RUN_BIT 3
`define LATCH_DMA_BIT 2
`define LATCH_BANK_HI 1
`define LATCH_BANK_LO 0
`define LATCH_RESET 4'h0
// ==========================================
// Counts
`define HOLDOFF_SHORT 4'h4
`define HOLDOFF_LONG 4'h8
`define BURST_MAX 4'h8
`define REFRESH_TOGGLE_COUNT 7'h7F
// ==========================================
// Clock derivation
`define CORE_CLK_HZ 100000000
`define SRC_CLK_HZ 16000000
`define SRC_DIV (`CORE_CLK_HZ / `SRC_CLK_HZ)
`endif

// ===== s100_slave_pkg.sv
package s100_slave_pkg;
  typedef struct packed {
    logic memr;
    logic inp;
    logic out;
    logic wo_n;
    logic dbin;
    logic wr_n;
    logic hlda;
  } host_status_t;

  typedef struct packed {
    logic mreq_n;
    logic iorq_n;
    logic rd_n;
    logic wr_n;
  } ext_strobes_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_RUN,
    ST_DONE,
    ST_YIELD
  } access_state_t;
endpackage

// ===== local_clock_refresh.sv
`timescale 1ns/1ps
`include "s100_slave_map.svh"
module local_clock_refresh #(
  parameter int SRC_DIV = `SRC_DIV
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic local_bus_grant_n,
  input wire logic refresh_strobe_n,
  input wire logic cpu_addr7,
  output logic cpu_clock,
  output logic cpu_tick,
  output logic synced_grant_n,
  output logic mem_addr_bit7
);
  logic [7:0] div_q, div_d;
  logic cpu_clock_q, cpu_clock_d;
  logic tick_q, tick_d;
  logic sync_q, sync_d;
  logic [6:0] rcnt_q, rcnt_d;
  logic rbit_q, rbit_d;
  logic refresh_strobe_n_prev_q, refresh_strobe_n_prev_d;
  logic a7_q, a7_d;

  always_comb begin
    div_d = div_q + 8'h01;
    cpu_clock_d = cpu_clock_q;
    tick_d = 1'b0;
    sync_d = sync_q;
    rcnt_d = rcnt_q;
    rbit_d = rbit_q;
    refresh_strobe_n_prev_d = refresh_strobe_n;
    // Source tick every SRC_DIV core clocks (100 MHz / 6, about 16.7 MHz, by default), halved into a symmetrical cpu clock
    if (div_q == 8'(SRC_DIV - 1)) begin
      div_d = 8'h00;
      cpu_clock_d = ~cpu_clock_q;
      tick_d = ~cpu_clock_q;
      // Grant taken only on the rising cpu clock, so bus addresses settle first
      if (!cpu_clock_q) begin
        sync_d = local_bus_grant_n;
      end
    end
    if (local_bus_grant_n) begin
      sync_d = 1'b1;
    end
    // Count refresh cycles on strobe fall
    if (refresh_strobe_n_prev_q && !refresh_strobe_n) begin
      rcnt_d = rcnt_q + 7'h01;
      if (rcnt_q == `REFRESH_TOGGLE_COUNT) begin
        rbit_d = ~rbit_q;
      end
    end
    a7_d = refresh_strobe_n ? cpu_addr7 : rbit_q;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 8'h00;
      cpu_clock_q <= 1'b0;
      tick_q <= 1'b0;
      sync_q <= 1'b1;
      rcnt_q <= 7'h00;
      rbit_q <= 1'b0;
      refresh_strobe_n_prev_q <= 1'b1;
      a7_q <= 1'b0;
    end else begin
      div_q <= div_d;
      cpu_clock_q <= cpu_clock_d;
      tick_q <= tick_d;
      sync_q <= sync_d;
      rcnt_q <= rcnt_d;
      rbit_q <= rbit_d;
      refresh_strobe_n_prev_q <= refresh_strobe_n_prev_d;
      a7_q <= a7_d;
    end
  end

  assign cpu_clock = cpu_clock_q;
  assign cpu_tick = tick_q;
  assign synced_grant_n = sync_q;
  assign mem_addr_bit7 = a7_q;
endmodule

// ===== s100_slave_board_access_assertions.sv
`timescale 1ns/1ps
module s100_slave_board_access_assertions (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic local_bus_grant_n,
  input wire logic refresh_strobe_n,
  input wire logic cpu_addr7,
  input wire logic mem_256k,
  input wire logic host_wait,
  input wire logic local_bus_request,
  input wire logic synced_grant_n,
  input wire logic mem_addr_bit7,
  input wire s100_slave_pkg::ext_strobes_t ext_strobes,
  input wire logic uart_chip_select_n,
  input wire logic control_latch_strobe_n,
  input wire logic host_selected_flag,
  input wire logic local_cpu_reset_n,
  input wire logic dma_board_flag_n,
  input wire logic [1:0] mem_bank
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // Completions within one grant period
  logic [3:0] done_cnt;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      done_cnt <= 4'h0;
    end else if (!local_bus_request) begin
      done_cnt <= 4'h0;
    end else if ($fell(host_wait)) begin
      done_cnt <= done_cnt + 4'h1;
    end
  end
  // ==========================================
  // Local bus handshake
  chk_strobe_sync: assert property ((&ext_strobes) || !synced_grant_n)
    else $error("external strobe without synced grant");
  chk_sync_grant: assert property ($fell(synced_grant_n) |-> !local_bus_grant_n)
    else $error("synced grant without local grant");
  // A yield may hold the host before the request returns
  chk_request_first: assert property ($rose(host_wait) |-> ##[0:40] local_bus_request)
    else $error("host held without bus request");
  // Hold-off spans several cpu ticks; the eighth completion yields instead
  chk_holdoff_min: assert property (($fell(host_wait) && done_cnt < 4'h7)
    |-> local_bus_request [*8])
    else $error("bus request dropped too early");
  chk_burst_yield: assert property (($fell(host_wait) && done_cnt == 4'h7)
    |-> ##[1:60] !local_bus_request)
    else $error("no yield after eight external cycles");
  // ==========================================
  // Control ports
  chk_latch_selected: assert property (!control_latch_strobe_n |-> host_selected_flag)
    else $error("latch strobe on unselected board");
  chk_latch_cause: assert property (($changed(local_cpu_reset_n) || $changed(dma_board_flag_n))
    |-> (!$past(control_latch_strobe_n, 1) || !$past(control_latch_strobe_n, 2)
    || !$past(control_latch_strobe_n, 3)))
    else $error("latch output changed without strobe");
  // ==========================================
  // Memory address path
  chk_bit7_pass: assert property ($past(resetn) && $past(refresh_strobe_n)
    |-> mem_addr_bit7 == $past(cpu_addr7))
    else $error("address bit 7 not passed through");
  chk_bank_ignored: assert property ($past(resetn) && !$past(mem_256k) |-> mem_bank == 2'h0)
    else $error("bank bits used with small memory");
  cov_host_done: cover property ($fell(host_wait));
  cov_cpu_run: cover property ($rose(local_cpu_reset_n));
  cov_uart: cover property (!uart_chip_select_n);
  cov_refresh_hi: cover property (!refresh_strobe_n && mem_addr_bit7);
endmodule

bind s100_slave_board_access s100_slave_board_access_assertions chk_inst (
  .core_clk(core_clk), .resetn(resetn), .local_bus_grant_n(local_bus_grant_n),
  .refresh_strobe_n(refresh_strobe_n), .cpu_addr7(cpu_addr7), .mem_256k(mem_256k),
  .host_wait(host_wait), .local_bus_request(local_bus_request),
  .synced_grant_n(synced_grant_n), .mem_addr_bit7(mem_addr_bit7),
  .ext_strobes(ext_strobes), .uart_chip_select_n(uart_chip_select_n),
  .control_latch_strobe_n(control_latch_strobe_n), .host_selected_flag(host_selected_flag),
  .local_cpu_reset_n(local_cpu_reset_n), .dma_board_flag_n(dma_board_flag_n),
  .mem_bank(mem_bank)
);

// ===== local_cpu_model.sv
`timescale 1ns/1ps
module local_cpu_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic local_bus_request,
  input wire logic local_cpu_reset_n,
  input wire s100_slave_pkg::ext_strobes_t ext_strobes,
  output logic local_bus_grant_n,
  output logic ext_cycle_done
);
  logic [1:0] lag;
  // ==========================================
  // Grant after a few cycles, never while held in reset
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lag <= 2'h0;
      local_bus_grant_n <= 1'b1;
      ext_cycle_done <= 1'b0;
    end else begin
      if (local_bus_request && local_cpu_reset_n) begin
        lag <= (lag == 2'h3) ? lag : lag + 2'h1;
        local_bus_grant_n <= (lag != 2'h3);
      end else begin
        lag <= 2'h0;
        local_bus_grant_n <= 1'b1;
      end
      ext_cycle_done <= !(&ext_strobes) && !ext_cycle_done;
    end
  end
endmodule

// ===== s100_slave_board_access_tb_top.sv
`timescale 1ns/1ps
module s100_slave_board_access_tb_top;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] host_addr = 16'h0000;
  logic [7:0] host_ext_addr = 8'h00;
  logic [7:0] host_data_out = 8'h00;
  s100_slave_pkg::host_status_t host_status = 7'h0A;
  logic [3:0] board_id_sw = 4'h5;
  logic [7:0] page_sw = 8'h0E;
  logic m1_wait_en = 1'b1;
  logic holdoff_long = 1'b0;
  logic mem_256k = 1'b1;
  logic opcode_fetch_cycle = 1'b0;
  logic refresh_strobe_n = 1'b1;
  logic cpu_addr7 = 1'b1;
  logic [5:2] uart_op = 4'h6;
  logic host_wait, inbound_buffer_en_n, outbound_buffer_en_n, local_bus_request, local_wait_n;
  logic cpu_clock, synced_grant_n, mem_addr_bit7, uart_chip_select_n, board_select_strobe_n;
  logic control_latch_strobe_n, host_selected_flag, local_cpu_reset_n, dma_board_flag_n;
  logic memory_window_hit_n, board_valid_n, local_bus_grant_n, ext_cycle_done;
  logic [3:0] uart_reg_addr;
  logic [1:0] mem_bank;
  s100_slave_pkg::ext_strobes_t ext_strobes;
  logic saw_wait, saw_hit, saw_in, saw_cs, saw_out, saw_bsel, saw_drop;
  logic [3:0] reg_seen;
  logic [1:0] bank_seen;
  int err_total = 0;
  int num_checks = 0;
  always #5 core_clk = ~core_clk;

  s100_slave_board_access #(.SRC_DIV(2)) s100_slave_board_access_inst (
    .core_clk(core_clk), .resetn(resetn), .host_addr(host_addr), .host_ext_addr(host_ext_addr),
    .host_data_out(host_data_out), .host_status(host_status), .board_id_sw(board_id_sw),
    .page_sw(page_sw), .m1_wait_en(m1_wait_en), .holdoff_long(holdoff_long),
    .mem_256k(mem_256k), .local_bus_grant_n(local_bus_grant_n),
    .opcode_fetch_cycle(opcode_fetch_cycle), .refresh_strobe_n(refresh_strobe_n),
    .cpu_addr7(cpu_addr7), .local_io_req(1'b0), .local_io_addr(8'h00), .uart_op(uart_op),
    .ext_cycle_done(ext_cycle_done), .host_wait(host_wait),
    .inbound_buffer_en_n(inbound_buffer_en_n), .outbound_buffer_en_n(outbound_buffer_en_n),
    .local_bus_request(local_bus_request), .local_wait_n(local_wait_n),
    .cpu_clock(cpu_clock), .synced_grant_n(synced_grant_n), .mem_addr_bit7(mem_addr_bit7),
    .ext_strobes(ext_strobes), .uart_chip_select_n(uart_chip_select_n),
    .uart_reg_addr(uart_reg_addr), .board_select_strobe_n(board_select_strobe_n),
    .control_latch_strobe_n(control_latch_strobe_n), .host_selected_flag(host_selected_flag),
    .local_cpu_reset_n(local_cpu_reset_n), .dma_board_flag_n(dma_board_flag_n),
    .mem_bank(mem_bank), .memory_window_hit_n(memory_window_hit_n),
    .board_valid_n(board_valid_n)
  );

  local_cpu_model local_cpu_model_inst (
    .core_clk(core_clk), .resetn(resetn), .local_bus_request(local_bus_request),
    .local_cpu_reset_n(local_cpu_reset_n), .ext_strobes(ext_strobes),
    .local_bus_grant_n(local_bus_grant_n), .ext_cycle_done(ext_cycle_done)
  );

  // ==========================================
  // Helpers
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the strobe until the board releases the host
  task automatic host_cyc(input logic [15:0] a, input logic [7:0] e, input logic [7:0] d,
      input logic [6:0] s);
    int n;
    n = 0;
    {saw_wait, saw_hit, saw_in, saw_cs, saw_out, saw_bsel, saw_drop} = 7'h00;
    @(posedge core_clk);
    host_addr <= a;
    host_ext_addr <= e;
    host_data_out <= d;
    host_status <= s;
    do begin
      @(posedge core_clk);
      n++;
      if (host_wait === 1'b1) saw_wait = 1'b1;
      if (memory_window_hit_n === 1'b0) saw_hit = 1'b1;
      if (inbound_buffer_en_n === 1'b0) saw_in = 1'b1;
      if (outbound_buffer_en_n === 1'b0) saw_out = 1'b1;
      if (board_select_strobe_n === 1'b0) saw_bsel = 1'b1;
      if (local_bus_request === 1'b0) saw_drop = 1'b1;
      if (ext_strobes.mreq_n === 1'b0) bank_seen = mem_bank;
      if (uart_chip_select_n === 1'b0) begin
        saw_cs = 1'b1;
        reg_seen = uart_reg_addr;
      end
    end while ((host_wait !== 1'b0 || n < 3) && n < 80);
    if (n >= 80) begin
      err_total++;
      tally_and_finish();
    end
    host_status <= 7'h0A;
    repeat (3) @(posedge core_clk);
  endtask

  initial begin : main
    int hi;
    int edges;
    logic last;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk(local_cpu_reset_n, 1'b0);
    chk(dma_board_flag_n, 1'b1);
    chk(mem_bank, 2'h0);
    chk(host_selected_flag, 1'b0);
    hi = 0;
    edges = 0;
    last = cpu_clock;
    repeat (40) begin
      @(posedge core_clk);
      hi += (cpu_clock === 1'b1);
      edges += (cpu_clock !== last);
      last = cpu_clock;
    end
    chk(hi, 20);
    chk(edges, 20);
    $display("test reset_and_clock done");
    host_cyc(16'hFC41, 8'h00, 8'h0F, 7'h10);
    chk(local_cpu_reset_n, 1'b0);
    host_cyc(16'hFC40, 8'h00, 8'h03, 7'h10);
    chk(host_selected_flag, 1'b0);
    chk(saw_bsel, 1'b1);
    host_cyc(16'hFC40, 8'h00, 8'hF5, 7'h10);
    chk(host_selected_flag, 1'b1);
    chk(board_valid_n, 1'b0);
    host_cyc(16'hFC41, 8'h00, 8'h0F, 7'h10);
    chk(local_cpu_reset_n, 1'b1);
    chk(dma_board_flag_n, 1'b0);
    chk(mem_bank, 2'h1);
    $display("test control_ports done");
    host_cyc(16'h1234, 8'h0E, 8'h00, 7'h4E);
    chk(saw_wait, 1'b1);
    chk(saw_hit, 1'b1);
    chk(saw_in, 1'b1);
    chk(bank_seen, 2'h3);
    chk(saw_out, 1'b1);
    host_cyc(16'h1234, 8'h0F, 8'h00, 7'h4E);
    chk(saw_wait, 1'b0);
    host_cyc(16'hFC35, 8'h00, 8'h00, 7'h2E);
    chk(saw_cs, 1'b1);
    chk(reg_seen, 4'h5);
    host_cyc(16'hFC40, 8'h00, 8'h02, 7'h10);
    chk(board_valid_n, 1'b1);
    host_cyc(16'h0040, 8'h0E, 8'h00, 7'h4F);
    chk(saw_hit, 1'b1);
    chk(bank_seen, 2'h2);
    host_cyc(16'hFC35, 8'h00, 8'h00, 7'h2E);
    chk(saw_cs, 1'b0);
    mem_256k <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(mem_bank, 2'h0);
    $display("test window_and_uart done");
    // DMA writes in one grant period; the ninth must wait out a yield
    for (int i = 1; i <= 9; i++) begin
      host_cyc(16'h0100, 8'h0E, 8'h5A, 7'h01);
      chk(saw_wait, 1'b1);
      chk(saw_in, 1'b0);
      if (i > 1) chk(saw_drop, i == 9);
    end
    $display("test dma_burst done");
    for (int i = 1; i <= 129; i++) begin
      refresh_strobe_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      if (i == 1) chk(mem_addr_bit7, 1'b0);
      if (i == 129) chk(mem_addr_bit7, 1'b1);
      refresh_strobe_n <= 1'b1;
      repeat (2) @(posedge core_clk);
    end
    chk(mem_addr_bit7, 1'b1);
    // Refresh bit is now 1, so a 0 here proves the pass-through
    cpu_addr7 <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(mem_addr_bit7, 1'b0);
    opcode_fetch_cycle <= 1'b1;
    hi = 0;
    repeat (4) begin
      @(posedge core_clk);
      if (local_wait_n === 1'b0) hi = 1;
    end
    chk(hi, 1);
    opcode_fetch_cycle <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(local_wait_n, 1'b1);
    m1_wait_en <= 1'b0;
    opcode_fetch_cycle <= 1'b1;
    hi = 0;
    repeat (4) begin
      @(posedge core_clk);
      if (local_wait_n === 1'b0) hi = 1;
    end
    chk(hi, 0);
    opcode_fetch_cycle <= 1'b0;
    $display("test refresh_and_fetch done");
    tally_and_finish();
  end
endmodule
